// ==== sfc_device.sv ====
// Purpose: Device end that frames flash commands from the serial link
// Assumes: Host stops the serial clock while chip select is high
// Notes: Frame contents cross to CLK after deselect, when they are static
// Operation
// - Bits move most significant first after select
// - Serial input sampled on each rising clock
// - Opcode byte first, then address or data
// - Host deselects after the last bit
// - Read type commands shift data out
// - Deselect stops output, returns to idle
// - Write type commands need byte boundary deselect
// - Partial program byte: nothing, latch kept
// - Decode enable, disable, status read and write
// - Latch clear refuses status write, program, erase
// - Reset pair and resume clear suspend flags
`timescale 1ns/1ps
`default_nettype none
module sfc_device
	import sfc_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h5A3C // arbitrary value
) (
	// System clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Link
	sfc_link_if.dev link,
	// Memory side
	input wire logic [7:0] ARRAY_DATA,
	input wire logic BUSY,
	input wire logic ERASE_ACTIVE,
	// Executed command
	output logic CMD_VALID,
	output logic [7:0] CMD_OPCODE,
	output logic [23:0] CMD_ADDR,
	output logic [7:0] CMD_DATA,
	// Status
	output logic WRITE_LATCH,
	output logic ERASE_SUSPENDED,
	output logic PROGRAM_SUSPENDED,
	output logic DEEP_POWER_DOWN,
	output logic SR_VOLATILE
);
	////////////////////////////////////////////////////////////////////////////
	// Link domain, rising edge: opcode, address and data capture
	logic frame_new_reg;
	logic [15:0] cnt_reg;
	logic [7:0] op_reg;
	logic [31:0] ad_reg;
	logic [7:0] dat_reg;
	logic [7:0] byte0_reg;
	logic got0_reg;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	wire sfc_info_t info = sfc_decode(op_reg);
	wire logic [15:0] hdr = 16'(`SFC_OP_BITS) + 16'(info.acyc) + 16'(info.dcyc);
	wire logic [15:0] cpb_m1 = 16'(`SFC_OP_BITS / info.ld) - 16'h0001;
	wire logic [15:0] pos = frame_new_reg ? 16'h0000 : cnt_reg;
	wire logic in_op = pos < 16'(`SFC_OP_BITS);
	wire logic in_adr = !in_op && pos < 16'(`SFC_OP_BITS) + 16'(info.acyc);
	wire logic in_dat = !in_op && info.wr && pos >= hdr;
	wire logic [3:0] g_adr = sfc_gather(link.io, info.la, `SFC_PIN_IN);
	wire logic [3:0] g_dat = sfc_gather(link.io, info.ld, `SFC_PIN_IN);
	wire logic [7:0] dat_next = 8'(dat_reg << info.ld) | {4'h0, g_dat};
	wire logic byte_end = ((pos - hdr) & cpb_m1) == cpb_m1;

	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			frame_new_reg <= 1'b1;
		end else begin
			frame_new_reg <= 1'b0;
		end
	end

	always_ff @(posedge link.sclk or posedge RESET) begin
		if (RESET) begin
			cnt_reg <= 16'h0000;
			op_reg <= 8'h00;
			ad_reg <= 32'h00000000;
			dat_reg <= 8'h00;
			byte0_reg <= 8'h00;
			got0_reg <= 1'b0;
		end else begin
			cnt_reg <= sat_inc(pos);
			if (in_op) begin
				op_reg <= {op_reg[6:0], link.io[`SFC_PIN_IN]};
			end
			if (in_adr) begin
				ad_reg <= 32'(ad_reg << info.la) | {28'h0, g_adr};
			end
			if (in_dat) begin
				dat_reg <= dat_next;
			end
			if (frame_new_reg) begin
				got0_reg <= 1'b0;
			end else if (in_dat && byte_end && !got0_reg) begin
				byte0_reg <= dat_next;
				got0_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain, falling edge: read data out
	logic [31:0] st_s1_reg;
	logic [31:0] st_s2_reg;
	logic [7:0] out_reg;
	logic [3:0] oe_reg;
	logic [1:0] id_idx_reg;
	logic [7:0] sr1_reg;
	logic [7:0] sr2_reg;
	logic [7:0] sr3_reg;

	wire logic [15:0] k = cnt_reg - hdr;
	wire logic rd_phase = info.rd && !frame_new_reg && cnt_reg >= hdr;
	wire logic load = (k & cpb_m1) == 16'h0000;
	wire logic [7:0] id_byte = (id_idx_reg == 2'd0) ? MAKER_ID :
		(id_idx_reg == 2'd1) ? PART_ID[15:8] : PART_ID[7:0];
	wire logic [7:0] src =
		(op_reg == `SFC_OP_RDSR1) ? st_s2_reg[31:24] :
		(op_reg == `SFC_OP_RDSR2) ? st_s2_reg[23:16] :
		(op_reg == `SFC_OP_RDSR3) ? st_s2_reg[15:8] :
		(op_reg == `SFC_OP_RDID) ? id_byte :
		(op_reg == `SFC_OP_RDP) ? PART_ID[7:0] : st_s2_reg[7:0];

	always_ff @(negedge link.sclk or posedge RESET) begin
		if (RESET) begin
			st_s1_reg <= 32'h00000000;
			st_s2_reg <= 32'h00000000;
		end else begin
			st_s1_reg <= {sr1_reg, sr2_reg, sr3_reg, ARRAY_DATA};
			st_s2_reg <= st_s1_reg;
		end
	end

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			oe_reg <= 4'h0;
			out_reg <= 8'h00;
			id_idx_reg <= 2'd0;
		end else if (rd_phase) begin
			oe_reg <= sfc_spread(4'hF, info.ld, `SFC_PIN_OUT);
			if (load) begin
				out_reg <= src;
				// Advance after every loaded byte so the next load sees the next ID byte
				id_idx_reg <= (id_idx_reg == `SFC_ID_BYTES) ? 2'd0 : id_idx_reg + 2'd1;
			end else begin
				out_reg <= 8'(out_reg << info.ld);
			end
		end
	end

	assign link.d_oe = oe_reg;
	assign link.d_out = sfc_spread(out_reg[7:4], info.ld, `SFC_PIN_OUT);

	////////////////////////////////////////////////////////////////////////////
	// CLK domain: deselect detection and execution
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic [64:0] fr_s1_reg;
	logic [64:0] fr_s2_reg;
	logic busy_s1_reg;
	logic busy_s2_reg;
	logic write_latch_flag_reg;
	logic erase_suspended_flag_reg;
	logic program_suspended_flag_reg;
	logic rsten_reg;
	logic dpd_reg;
	logic vol_reg;
	logic volarm_reg;
	logic [5:0] sr1w_reg;
	logic [7:0] sr2w_reg;

	wire logic cs_rise = cs_s2_reg && !cs_s3_reg;
	wire logic [7:0] b_op = fr_s2_reg[64:57];
	wire logic [15:0] b_cnt = fr_s2_reg[56:41];
	wire logic [31:0] b_ad = fr_s2_reg[39:8];
	wire logic [7:0] b_dat = fr_s2_reg[7:0];
	// Frame start flag is already set by deselect, so the held count is the pulse count
	wire logic [15:0] b_pul = b_cnt;
	wire logic bound = b_pul != 16'h0000 && b_pul[2:0] == 3'b000;
	wire logic [15:0] b_op_end = 16'(`SFC_OP_BITS);
	wire logic [15:0] b_adr_end = b_op_end + 16'(`SFC_ADDR_BITS);
	wire logic is_sr_wr = b_op == `SFC_OP_WRSR1 || b_op == `SFC_OP_WRSR2 ||
		b_op == `SFC_OP_WRSR3;
	wire logic is_prog = b_op == `SFC_OP_PP || b_op == `SFC_OP_QPP || b_op == `SFC_OP_FPP;
	wire logic is_erase = b_op == `SFC_OP_SE || b_op == `SFC_OP_BE32 || b_op == `SFC_OP_BE64;
	wire logic is_chip = b_op == `SFC_OP_CE1 || b_op == `SFC_OP_CE2;
	wire logic len_ok = is_sr_wr ? b_pul > b_op_end :
		is_prog ? b_pul > b_adr_end :
		is_erase ? b_pul == b_adr_end : b_pul == b_op_end;
	wire logic go = cs_rise && bound && len_ok && !dpd_reg;
	wire logic wgo = go && write_latch_flag_reg &&
		(is_sr_wr || is_prog || is_erase || is_chip);
	wire logic rst_go = go && b_op == `SFC_OP_RST && rsten_reg;
	wire logic sus_go = go && b_op == `SFC_OP_SUSP && busy_s2_reg;

	assign sr1_reg = {sr1w_reg, write_latch_flag_reg, busy_s2_reg};
	assign sr2_reg = {erase_suspended_flag_reg, sr2w_reg[6:3], program_suspended_flag_reg,
		sr2w_reg[1:0]};

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			fr_s1_reg <= 65'h0;
			fr_s2_reg <= 65'h0;
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= link.cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			fr_s1_reg <= {op_reg, cnt_reg, frame_new_reg, ad_reg, byte0_reg};
			fr_s2_reg <= fr_s1_reg;
			busy_s1_reg <= BUSY;
			busy_s2_reg <= busy_s1_reg;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			write_latch_flag_reg <= 1'b0;
			erase_suspended_flag_reg <= 1'b0;
			program_suspended_flag_reg <= 1'b0;
			rsten_reg <= 1'b0;
			dpd_reg <= 1'b0;
			vol_reg <= 1'b0;
			volarm_reg <= 1'b0;
			sr1w_reg <= 6'h00;
			sr2w_reg <= 8'h00;
			sr3_reg <= 8'h00;
			CMD_VALID <= 1'b0;
			CMD_OPCODE <= 8'h00;
			CMD_ADDR <= 24'h000000;
			CMD_DATA <= 8'h00;
		end else begin
			CMD_VALID <= wgo;
			if (wgo) begin
				CMD_OPCODE <= b_op;
				CMD_ADDR <= b_ad[23:0];
				CMD_DATA <= b_dat;
				vol_reg <= volarm_reg;
			end
			if (go && b_op == `SFC_WRITE_ENABLE_CMD) begin
				write_latch_flag_reg <= 1'b1;
			end else if (wgo || rst_go || (go && b_op == `SFC_WRITE_DISABLE_CMD)) begin
				write_latch_flag_reg <= 1'b0;
			end
			if (go && b_op == `SFC_OP_VSRWE) begin
				volarm_reg <= 1'b1;
			end else if (wgo || rst_go) begin
				volarm_reg <= 1'b0;
			end
			if (wgo && b_op == `SFC_OP_WRSR1) begin
				sr1w_reg <= b_dat[7:2];
			end
			if (wgo && b_op == `SFC_OP_WRSR2) begin
				sr2w_reg <= b_dat;
			end
			if (wgo && b_op == `SFC_OP_WRSR3) begin
				sr3_reg <= b_dat;
			end
			if (sus_go && ERASE_ACTIVE) begin
				erase_suspended_flag_reg <= 1'b1;
			end else if (rst_go || (go && b_op == `SFC_OP_RESUME)) begin
				erase_suspended_flag_reg <= 1'b0;
			end
			if (sus_go && !ERASE_ACTIVE) begin
				program_suspended_flag_reg <= 1'b1;
			end else if (rst_go || (go && b_op == `SFC_OP_RESUME)) begin
				program_suspended_flag_reg <= 1'b0;
			end
			if (cs_rise) begin
				rsten_reg <= go && b_op == `SFC_OP_RSTEN;
			end
			if (go && b_op == `SFC_OP_DPD) begin
				dpd_reg <= 1'b1;
			end else if (cs_rise && b_op == `SFC_OP_RDP) begin
				dpd_reg <= 1'b0;
			end
		end
	end

	assign WRITE_LATCH = write_latch_flag_reg;
	assign ERASE_SUSPENDED = erase_suspended_flag_reg;
	assign PROGRAM_SUSPENDED = program_suspended_flag_reg;
	assign DEEP_POWER_DOWN = dpd_reg;
	assign SR_VOLATILE = vol_reg;
endmodule
`default_nettype wire

// ==== sfc_host.sv ====
// Purpose: Host end that drives chip select, serial clock and data lanes
// Assumes: CLK is at least SFC_MIN_HALF times faster than half a serial period
// Notes: Serial clock is CLK divided by two times HALF
`timescale 1ns/1ps
`default_nettype none
module sfc_host
	import sfc_pkg::*;
#(
	parameter int HALF = 4
) (
	// System clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Command request
	input wire logic START,
	input wire logic [7:0] OPCODE,
	input wire logic [23:0] ADDR,
	input wire logic [7:0] MODE,
	input wire logic [7:0] WDATA,
	input wire logic [7:0] WR_BYTES,
	input wire logic [2:0] EXTRA_PULSES,
	input wire logic [7:0] RD_BYTES,
	// Answer
	output logic BUSY,
	output logic DONE,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	// Link
	sfc_link_if.host link
);
	if (HALF < `SFC_MIN_HALF) begin : g_chk
		$error("HALF too small for the read synchroniser");
	end

	typedef enum {SFC_IDLE, SFC_RUN, SFC_TAIL} sfc_hstate_t;
	sfc_hstate_t state_reg;
	logic [15:0] div_reg;
	logic cs_n_reg;
	logic sclk_reg;
	logic [2:0] ph_reg;
	logic [15:0] left_reg;
	logic [15:0] plen_reg [0:`SFC_PH_RD];
	logic [7:0] op_reg;
	logic [31:0] tx_reg;
	logic [7:0] wd_reg;
	logic [7:0] rx_reg;
	logic [3:0] rxn_reg;
	logic [3:0] io_s1_reg;
	logic [3:0] io_s2_reg;
	sfc_info_t info_reg;
	logic [2:0] nph;

	wire sfc_info_t req = sfc_decode(OPCODE);
	wire logic tick = div_reg == 16'(HALF - 1);
	wire logic [3:0] rx_g = sfc_gather(io_s2_reg, info_reg.ld, `SFC_PIN_OUT);
	wire logic [7:0] rx_next = 8'(rx_reg << info_reg.ld) | {4'h0, rx_g};
	wire logic [3:0] rxn_next = rxn_reg + {1'b0, info_reg.ld};
	wire logic [15:0] cpb = 16'(`SFC_OP_BITS / req.ld);

	always_comb begin
		nph = 3'(`SFC_PH_END);
		for (int p = `SFC_PH_RD; p > `SFC_PH_OP; p--) begin
			if (3'(p) > ph_reg && plen_reg[p] != 16'h0000) begin
				nph = 3'(p);
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			io_s1_reg <= 4'hF;
			io_s2_reg <= 4'hF;
		end else begin
			io_s1_reg <= link.io;
			io_s2_reg <= io_s1_reg;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_reg <= SFC_IDLE;
			div_reg <= 16'h0000;
			cs_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
			ph_reg <= 3'(`SFC_PH_OP);
			left_reg <= 16'h0000;
			for (int p = 0; p <= `SFC_PH_RD; p++) begin
				plen_reg[p] <= 16'h0000;
			end
			op_reg <= 8'h00;
			tx_reg <= 32'h00000000;
			wd_reg <= 8'h00;
			rx_reg <= 8'h00;
			rxn_reg <= 4'h0;
			info_reg <= '0;
			DONE <= 1'b0;
			RD_VALID <= 1'b0;
			RD_DATA <= 8'h00;
		end else begin
			DONE <= 1'b0;
			RD_VALID <= 1'b0;
			div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
			case (state_reg)
				SFC_IDLE: begin
					div_reg <= 16'h0000;
					if (START) begin
						state_reg <= SFC_RUN;
						cs_n_reg <= 1'b0;
						ph_reg <= 3'(`SFC_PH_OP);
						left_reg <= 16'(`SFC_OP_BITS);
						plen_reg[0] <= 16'(`SFC_OP_BITS);
						plen_reg[1] <= 16'(req.acyc);
						plen_reg[2] <= 16'(req.dcyc);
						plen_reg[3] <= 16'(WR_BYTES) * cpb + 16'(EXTRA_PULSES);
						plen_reg[4] <= req.rd ? 16'(RD_BYTES) * cpb : 16'h0000;
						op_reg <= OPCODE;
						tx_reg <= {ADDR, (req.la == `SFC_LANE_1) ? 8'h00 : MODE};
						wd_reg <= WDATA;
						rxn_reg <= 4'h0;
						info_reg <= req;
					end
				end
				SFC_RUN: begin
					if (tick && !sclk_reg) begin
						sclk_reg <= 1'b1;
						if (ph_reg == 3'(`SFC_PH_RD)) begin
							rx_reg <= rx_next;
							rxn_reg <= (rxn_next == 4'(`SFC_OP_BITS)) ? 4'h0 : rxn_next;
							if (rxn_next == 4'(`SFC_OP_BITS)) begin
								RD_DATA <= rx_next;
								RD_VALID <= 1'b1;
							end
						end
					end else if (tick) begin
						sclk_reg <= 1'b0;
						case (ph_reg)
							3'd0: op_reg <= {op_reg[6:0], 1'b0};
							3'd1: tx_reg <= 32'(tx_reg << info_reg.la);
							3'd3: wd_reg <= 8'((wd_reg << info_reg.ld) |
								(wd_reg >> (`SFC_OP_BITS - info_reg.ld)));
							default: rx_reg <= rx_reg;
						endcase
						left_reg <= left_reg - 16'h0001;
						if (left_reg == 16'h0001) begin
							ph_reg <= nph;
							left_reg <= (nph == 3'(`SFC_PH_END)) ? 16'h0000 : plen_reg[nph];
							if (nph == 3'(`SFC_PH_END)) begin
								state_reg <= SFC_TAIL;
							end
						end
					end
				end
				default: begin
					if (tick) begin
						cs_n_reg <= 1'b1;
						DONE <= 1'b1;
						state_reg <= SFC_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lane drive for the current pulse
	wire logic drv_op = state_reg == SFC_RUN && ph_reg == 3'(`SFC_PH_OP);
	wire logic drv_ad = state_reg == SFC_RUN && ph_reg == 3'd1;
	wire logic drv_wd = state_reg == SFC_RUN && ph_reg == 3'(`SFC_PH_WR);

	assign link.cs_n = cs_n_reg;
	assign link.sclk = sclk_reg;
	assign link.h_oe = drv_op ? 4'h1 :
		drv_ad ? sfc_spread(4'hF, info_reg.la, `SFC_PIN_IN) :
		drv_wd ? sfc_spread(4'hF, info_reg.ld, `SFC_PIN_IN) : 4'h0;
	assign link.h_out = drv_op ? {3'b000, op_reg[7]} :
		drv_ad ? sfc_spread(tx_reg[31:28], info_reg.la, `SFC_PIN_IN) :
		drv_wd ? sfc_spread(wd_reg[7:4], info_reg.ld, `SFC_PIN_IN) : 4'h0;
	assign BUSY = state_reg != SFC_IDLE;
endmodule
`default_nettype wire

// ==== sfc_link_if.sv ====
// Purpose: Serial flash link between host controller and device
// Assumes: Each end drives only its own outputs and enables
// Notes: Undriven data lanes read as high
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] h_out;
	logic [3:0] h_oe;
	logic [3:0] d_out;
	logic [3:0] d_oe;
	wire logic [3:0] io;

	assign io = (d_oe & d_out) | (~d_oe & h_oe & h_out) | (~d_oe & ~h_oe);

	modport host (output cs_n, output sclk, output h_out, output h_oe, input io);
	modport dev (input cs_n, input sclk, input io, output d_out, output d_oe);
endinterface
`default_nettype wire

// ==== sfc_link_sva.sv ====
// Purpose: Timing checks on the link between host and device ends
// Assumes: Serial clock is made from CLK, so one domain suffices
// Notes: HALF must match the host instance
`timescale 1ns/1ps
`default_nettype none
module sfc_link_sva #(
	parameter int HALF = 4
) (
	// System
	input wire logic CLK,
	input wire logic RESET,
	// Link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] h_out,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_out,
	input wire logic [3:0] d_oe,
	input wire logic [3:0] io
);
	logic [7:0] hi_reg;
	logic [7:0] hi_next;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	////////////////////////////////////////////////////////////////
	// Length of the current high phase of the serial clock
	assign hi_next = sclk ? hi_reg + 8'h01 : 8'h00;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			hi_reg <= 8'h00;
		end else begin
			hi_reg <= hi_next;
		end
	end
	////////////////////////////////////////////////////////////////
	idle_clock_a: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	quiet_dev_a: assert property (cs_n && $past(cs_n) |-> d_oe == 4'h0)
		else $error("device drives while deselected");
	no_fight_a: assert property ((d_oe & h_oe) == 4'h0)
		else $error("both ends drive one lane");
	first_bit_a: assert property ($fell(cs_n) |-> (h_oe[0] && !sclk)[*4] ##1 sclk)
		else $error("first bit not set up before first rise");
	high_time_a: assert property ($fell(sclk) |-> hi_reg == 8'(HALF))
		else $error("serial clock high phase wrong");
	low_time_a: assert property ($fell(sclk) |-> (!sclk)[*4])
		else $error("serial clock low phase short");
	end_gap_a: assert property ($rose(cs_n) |-> !$past(sclk) && !$past(sclk, 4))
		else $error("deselect too close to last pulse");
	out_edge_a: assert property (d_oe[1] && $changed(d_out[1]) |-> !sclk)
		else $error("device output moved while clock high");
endmodule
`default_nettype wire

// ==== sfc_map.svh ====
// Purpose: Opcodes, frame lengths and field positions of the flash command framer
// Assumes: Included by the package only; both ends use its macros
// Notes: Definitions only
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_WRITE_ENABLE_CMD 8'h06
`define SFC_WRITE_DISABLE_CMD 8'h04
`define SFC_OP_VSRWE 8'h50
`define SFC_OP_RDSR1 8'h05
`define SFC_OP_RDSR2 8'h35
`define SFC_OP_RDSR3 8'h15
`define SFC_OP_WRSR1 8'h01
`define SFC_OP_WRSR2 8'h31
`define SFC_OP_WRSR3 8'h11
`define SFC_OP_READ 8'h03
`define SFC_OP_FREAD 8'h0B
`define SFC_OP_DOREAD 8'h3B
`define SFC_OP_QOREAD 8'h6B
`define SFC_OP_DIOREAD 8'hBB
`define SFC_OP_QIOREAD 8'hEB
`define SFC_OP_QIOWREAD 8'hE7
`define SFC_OP_PP 8'h02
`define SFC_OP_QPP 8'h32
`define SFC_OP_FPP 8'hF2
`define SFC_OP_SE 8'h20
`define SFC_OP_BE32 8'h52
`define SFC_OP_BE64 8'hD8
`define SFC_OP_CE1 8'hC7
`define SFC_OP_CE2 8'h60
`define SFC_OP_DPD 8'hB9
`define SFC_OP_RDP 8'hAB
`define SFC_OP_RDID 8'h9F
`define SFC_OP_SUSP 8'h75
`define SFC_OP_RESUME 8'h7A
`define SFC_OP_RSTEN 8'h66
`define SFC_OP_RST 8'h99
`define SFC_OP_BITS 8
`define SFC_ADDR_BITS 24
`define SFC_AM_BITS 32
`define SFC_DUMMY_BITS 8
`define SFC_QIO_DUMMY 4
`define SFC_QIOW_DUMMY 2
`define SFC_RDP_DUMMY 24
`define SFC_LANE_1 3'd1
`define SFC_LANE_2 3'd2
`define SFC_LANE_4 3'd4
`define SFC_PIN_IN 1'b0
`define SFC_PIN_OUT 1'b1
`define SFC_ID_BYTES 2'd2
`define SFC_SR1_WRITE_LATCH_FLAG 1
`define SFC_SR1_BUSY 0
`define SFC_SR2_ERASE_SUSPENDED_FLAG 7
`define SFC_SR2_PROGRAM_SUSPENDED_FLAG 2
`define SFC_PH_OP 0
`define SFC_PH_WR 3
`define SFC_PH_RD 4
`define SFC_PH_END 5
`define SFC_MIN_HALF 4
`endif

// ==== sfc_pkg.sv ====
// Purpose: Types and shared decode for the flash command framer
// Assumes: sfc_map.svh supplies every number
// Notes: Both ends decode frames with the same function
`default_nettype none
package sfc_pkg;
`include "sfc_map.svh"
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] la;
		logic [5:0] acyc;
		logic [5:0] dcyc;
		logic [2:0] ld;
	} sfc_info_t;

	function automatic sfc_info_t sfc_decode(input logic [7:0] op);
		sfc_info_t i;
		i = '{rd: 1'b0, wr: 1'b0, la: `SFC_LANE_1, acyc: 6'd0, dcyc: 6'd0, ld: `SFC_LANE_1};
		case (op)
			`SFC_OP_READ: begin
				i.rd = 1'b1;
				i.acyc = 6'(`SFC_ADDR_BITS);
			end
			`SFC_OP_FREAD, `SFC_OP_DOREAD, `SFC_OP_QOREAD: begin
				i.rd = 1'b1;
				i.acyc = 6'(`SFC_ADDR_BITS);
				i.dcyc = 6'(`SFC_DUMMY_BITS);
				i.ld = (op == `SFC_OP_FREAD) ? `SFC_LANE_1 :
					(op == `SFC_OP_DOREAD) ? `SFC_LANE_2 : `SFC_LANE_4;
			end
			`SFC_OP_DIOREAD: begin
				i.rd = 1'b1;
				i.la = `SFC_LANE_2;
				i.ld = `SFC_LANE_2;
				i.acyc = 6'(`SFC_AM_BITS / `SFC_LANE_2);
			end
			`SFC_OP_QIOREAD, `SFC_OP_QIOWREAD: begin
				i.rd = 1'b1;
				i.la = `SFC_LANE_4;
				i.ld = `SFC_LANE_4;
				i.acyc = 6'(`SFC_AM_BITS / `SFC_LANE_4);
				i.dcyc = (op == `SFC_OP_QIOREAD) ? 6'(`SFC_QIO_DUMMY) : 6'(`SFC_QIOW_DUMMY);
			end
			`SFC_OP_RDSR1, `SFC_OP_RDSR2, `SFC_OP_RDSR3, `SFC_OP_RDID: i.rd = 1'b1;
			`SFC_OP_RDP: begin
				i.rd = 1'b1;
				i.dcyc = 6'(`SFC_RDP_DUMMY);
			end
			`SFC_OP_WRSR1, `SFC_OP_WRSR2, `SFC_OP_WRSR3: i.wr = 1'b1;
			`SFC_OP_PP, `SFC_OP_FPP, `SFC_OP_QPP: begin
				i.wr = 1'b1;
				i.acyc = 6'(`SFC_ADDR_BITS);
				i.ld = (op == `SFC_OP_QPP) ? `SFC_LANE_4 : `SFC_LANE_1;
			end
			`SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64: i.acyc = 6'(`SFC_ADDR_BITS);
			default: i.rd = 1'b0;
		endcase
		return i;
	endfunction

	// Picks the lanes of a bus that carry bits for the given width
	function automatic logic [3:0] sfc_gather(input logic [3:0] io, input logic [2:0] n,
		input logic pin);
		case (n)
			`SFC_LANE_4: return io;
			`SFC_LANE_2: return {2'b00, io[1:0]};
			default: return {3'b000, io[pin]};
		endcase
	endfunction

	// Places the top bits of a byte onto the lanes for the given width
	function automatic logic [3:0] sfc_spread(input logic [3:0] top, input logic [2:0] n,
		input logic pin);
		case (n)
			`SFC_LANE_4: return top;
			`SFC_LANE_2: return {2'b00, top[3:2]};
			default: return pin ? {2'b00, top[3], 1'b0} : {3'b000, top[3]};
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Runs host and device ends against each other
// Assumes: Host derives the serial clock from CLK
// Notes: Each scenario judges its own outcome
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] MK = 8'h3C; // arbitrary value
	localparam logic [15:0] PT = 16'h7E81; // arbitrary value
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic start = 1'h0;
	logic [7:0] op = 8'h00;
	logic [23:0] ad = 24'h000000;
	logic [7:0] wd = 8'h00;
	logic [7:0] wn = 8'h00;
	logic [2:0] ex = 3'h0;
	logic [7:0] rn = 8'h00;
	logic [7:0] arr = 8'h00;
	logic d_busy = 1'h0;
	logic erase_on = 1'h0;
	logic h_busy, done, rd_valid, cmd_valid, wl, es, ps, dpd, srv;
	logic [7:0] rd_data, cmd_op, cmd_data;
	logic [23:0] cmd_addr;
	logic [7:0] rdq[$];
	int err_total = 0;
	int cmp_count = 0;
	int execs = 0;
	sfc_link_if link();
	sfc_host #(.HALF(4)) i_sfc_host(.CLK(clk), .RESET(rst), .START(start), .OPCODE(op),
		.ADDR(ad), .MODE(8'h00), .WDATA(wd), .WR_BYTES(wn), .EXTRA_PULSES(ex),
		.RD_BYTES(rn), .BUSY(h_busy), .DONE(done), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .link(link));
	sfc_device #(.MAKER_ID(MK), .PART_ID(PT)) i_sfc_device(.CLK(clk), .RESET(rst),
		.link(link), .ARRAY_DATA(arr), .BUSY(d_busy), .ERASE_ACTIVE(erase_on),
		.CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_op), .CMD_ADDR(cmd_addr),
		.CMD_DATA(cmd_data), .WRITE_LATCH(wl), .ERASE_SUSPENDED(es),
		.PROGRAM_SUSPENDED(ps), .DEEP_POWER_DOWN(dpd), .SR_VOLATILE(srv));
	sfc_link_sva #(.HALF(4)) i_sfc_link_sva(.CLK(clk), .RESET(rst), .cs_n(link.cs_n),
		.sclk(link.sclk), .h_out(link.h_out), .h_oe(link.h_oe), .d_out(link.d_out),
		.d_oe(link.d_oe), .io(link.io));
	always #5 clk = ~clk;
	always @(negedge clk) begin
		if (rd_valid === 1'h1) rdq.push_back(rd_data);
		if (cmd_valid === 1'h1) execs++;
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One framed command; waits for deselect and for the device to act
	task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic [7:0] d,
		input logic [7:0] w, input logic [2:0] x, input logic [7:0] r);
		int n;
		n = 0;
		rdq.delete();
		@(posedge clk);
		start <= 1'h1;
		op <= o;
		ad <= a;
		wd <= d;
		wn <= w;
		ex <= x;
		rn <= r;
		@(posedge clk);
		start <= 1'h0;
		while (done !== 1'h1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk("done", 24'(n < 3000), 24'h1);
		repeat (8) @(negedge clk);
		chk("host idle", h_busy, 1'h0);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_latch;
		cmd(8'h06, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("latch set", wl, 1'h1);
		cmd(8'h05, 24'h0, 8'h0, 8'h0, 3'h0, 8'h2);
		chk("sr1 count", 24'(rdq.size()), 24'h2);
		chk("sr1 a", rdq[0][1:0], 2'h2);
		chk("sr1 b", rdq[1][1:0], 2'h2);
		cmd(8'h04, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("latch clr", wl, 1'h0);
		cmd(8'h06, 24'h0, 8'h0, 8'h0, 3'h3, 8'h0);
		chk("odd enable", wl, 1'h0);
		cmd(8'h50, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		cmd(8'h06, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		cmd(8'h01, 24'h0, 8'h00, 8'h1, 3'h0, 8'h0);
		chk("volatile", srv, 1'h1);
	endtask
	task automatic s_gate;
		logic [7:0] ops[11] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h01, 8'h31,
			8'h11, 8'h02, 8'h32, 8'hF2};
		execs = 0;
		cmd(8'h20, 24'hA51C3E, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("no latch", 24'(execs), 24'h0);
		cmd(8'h06, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		cmd(8'h20, 24'hA51C3E, 8'h0, 8'h0, 3'h3, 8'h0);
		chk("odd erase", 24'(execs), 24'h0);
		cmd(8'h02, 24'hA51C3E, 8'h5A, 8'h1, 3'h3, 8'h0);
		chk("part byte", 24'(execs), 24'h0);
		chk("latch kept", wl, 1'h1);
		cmd(8'h20, 24'hA51C3E, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("erase addr", cmd_addr, 24'hA51C3E);
		for (int i = 0; i < 11; i++) begin
			cmd(8'h06, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
			// Quad data takes two pulses a byte: four bytes keep the byte boundary
			cmd(ops[i], 24'h0F00F1, 8'h96, (ops[i] == 8'h32) ? 8'h4 : 8'(i > 4), 3'h0, 8'h0);
			chk("exec", 24'(execs), 24'(i + 2));
			chk("opcode", cmd_op, ops[i]);
			chk("used latch", wl, 1'h0);
		end
		chk("data", cmd_data, 8'h96);
		chk("addr", cmd_addr, 24'h0F00F1);
	endtask
	task automatic s_reads;
		logic [7:0] ops[7] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hE7};
		@(posedge clk);
		arr <= 8'hC5;
		for (int i = 0; i < 7; i++) begin
			cmd(ops[i], 24'h001234, 8'h0, 8'h0, 3'h0, 8'h2);
			chk("rd count", 24'(rdq.size()), 24'h2);
			chk("rd a", rdq[0], 8'hC5);
			chk("rd b", rdq[1], 8'hC5);
		end
		cmd(8'h9F, 24'h0, 8'h0, 8'h0, 3'h0, 8'h3);
		chk("id", {rdq[0], rdq[1], rdq[2]}, {MK, PT});
	endtask
	task automatic s_susp;
		@(posedge clk);
		d_busy <= 1'h1;
		erase_on <= 1'h1;
		cmd(8'h75, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("erase susp", es, 1'h1);
		cmd(8'h7A, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("resume", es, 1'h0);
		@(posedge clk);
		erase_on <= 1'h0;
		cmd(8'h75, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		cmd(8'h99, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("unarmed rst", ps, 1'h1);
		cmd(8'h66, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		cmd(8'h99, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("reset pair", ps, 1'h0);
		@(posedge clk);
		d_busy <= 1'h0;
	endtask
	task automatic s_dpd;
		cmd(8'h06, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		cmd(8'hB9, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("sleep", dpd, 1'h1);
		cmd(8'h04, 24'h0, 8'h0, 8'h0, 3'h0, 8'h0);
		chk("asleep", wl, 1'h1);
		cmd(8'hAB, 24'h0, 8'h0, 8'h0, 3'h0, 8'h1);
		chk("wake", dpd, 1'h0);
		chk("wake id", rdq[0], PT[7:0]);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		s_latch;
		s_gate;
		s_reads;
		s_susp;
		s_dpd;
		test_done;
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		test_done;
	end
endmodule
`default_nettype wire
